// ==== inc/magnetic_pickup_input_pkg.sv ====
// constants and types for the automatic telecoil memory switch
package telecoil_pkg;

  // ------------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] debounce_addr = 8'h04;
  localparam logic [7:0] valid_addr = 8'h08;
  localparam logic [7:0] front_end_addr = 8'h0c;
  localparam logic [7:0] status_addr = 8'h10;

  // ctrl fields
  localparam int ctrl_auto_bit = 0;
  localparam int ctrl_pullup_bit = 1;
  localparam int ctrl_sel_lsb = 4;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] debounce_reset = 16'h0100;
  localparam logic [3:0] valid_reset = 4'h1;
  localparam logic [11:0] front_end_reset = 12'h000;

  localparam int debounce_width = 16;
  localparam int mem_count = 4;
  localparam int mode_width = 3;

  typedef enum logic [1:0] {
    mem_a = 2'b00,
    mem_b = 2'b01,
    mem_c = 2'b10,
    mem_d = 2'b11
  } memory_e;

  typedef enum logic [2:0] {
    fe_single_omni = 3'b000,
    fe_rear_omni = 3'b001,
    fe_directional = 3'b010,
    fe_dual_omni = 3'b011,
    fe_direct_audio = 3'b100,
    fe_telecoil = 3'b101,
    fe_mic_telecoil = 3'b110,
    fe_mic_direct = 3'b111
  } front_end_e;

endpackage

// ==== verilog/open_debouncer.sv ====
// debounce counter judging the reed switch open
`timescale 1ns/1ns
module open_debouncer #(
  parameter int width = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic closed,
  input wire logic [width-1:0] period,
  output logic running,
  output logic done
);

  logic [width-1:0] count;
  wire logic at_end = running && !closed && (count >= period);

  assign done = at_end;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running <= 1'b0;
      count <= '0;
    end else if (closed) begin
      // any closed sample aborts; rearm at next release
      running <= 1'b0;
      count <= '0;
    end else if (start) begin
      running <= 1'b1;
      count <= width'(1);
    end else if (at_end) begin
      running <= 1'b0;
      count <= '0;
    end else if (running) begin
      count <= count + width'(1);
    end
  end

endmodule // open_debouncer

// ==== verilog/telecoil_memory_switch.sv ====
// automatic telecoil memory switch with ahb-lite register slave
`timescale 1ns/1ns
module telecoil_memory_switch #(
  parameter int debounce_width = telecoil_pkg::debounce_width
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic memory_select_input_two,
  output logic [1:0] active_memory,
  output logic [2:0] active_front_end,
  output logic telecoil_forced
);

  // ------------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------------
  logic wr_pending;
  logic [7:0] wr_addr;
  logic auto_enable;
  logic pull_high;
  logic [1:0] user_memory;
  logic [debounce_width-1:0] debounce_period;
  logic [3:0] valid_mask;
  logic [11:0] front_end_cfg;

  wire logic access = hsel && hready && htrans[1];
  wire logic [7:0] word_addr = {haddr[7:2], 2'b00};

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pending <= access && hwrite;
      wr_addr <= word_addr;
    end
  end

  wire logic wr_ctrl = wr_pending && wr_addr == telecoil_pkg::ctrl_addr;
  wire logic wr_deb = wr_pending && wr_addr == telecoil_pkg::debounce_addr;
  wire logic wr_valid = wr_pending && wr_addr == telecoil_pkg::valid_addr;
  wire logic wr_fe = wr_pending && wr_addr == telecoil_pkg::front_end_addr;

  // memory a stays valid whatever software writes
  wire logic [3:0] next_valid = {hwdata[3:1], 1'b1};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_enable <= 1'b0;
      pull_high <= 1'b0;
      user_memory <= 2'b00;
      debounce_period <= debounce_width'(telecoil_pkg::debounce_reset);
      valid_mask <= telecoil_pkg::valid_reset;
      front_end_cfg <= telecoil_pkg::front_end_reset;
    end else begin
      if (wr_ctrl) begin
        auto_enable <= hwdata[telecoil_pkg::ctrl_auto_bit];
        pull_high <= hwdata[telecoil_pkg::ctrl_pullup_bit];
        user_memory <= hwdata[telecoil_pkg::ctrl_sel_lsb +: 2];
      end
      if (wr_deb) begin
        debounce_period <= hwdata[debounce_width-1:0];
      end
      if (wr_valid) begin
        valid_mask <= next_valid;
      end
      if (wr_fe) begin
        front_end_cfg <= hwdata[11:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // switch sensing and memory forcing
  // ------------------------------------------------------------------
  // pull-up wiring means closed pulls the pin low
  wire logic closed = pull_high ? !memory_select_input_two
                                : memory_select_input_two;
  logic closed_q;
  logic forced;
  logic [1:0] saved_memory;
  logic deb_running;
  logic deb_done;

  wire logic release_edge = forced && closed_q && !closed;
  // invalid user choice falls back to a, which is always valid
  wire logic [1:0] user_eff = valid_mask[user_memory] ? user_memory
                                                       : 2'b00;

  open_debouncer #(
    .width(debounce_width)
  ) u_debounce (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(release_edge),
    .closed(closed),
    .period(debounce_period),
    .running(deb_running),
    .done(deb_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      closed_q <= 1'b0;
      forced <= 1'b0;
      saved_memory <= 2'b00;
      active_memory <= 2'b00;
      active_front_end <= 3'b000;
    end else begin
      closed_q <= closed;
      if (!forced && auto_enable && closed) begin
        forced <= 1'b1;
        saved_memory <= user_eff;
      end else if (forced && (deb_done || !auto_enable)) begin
        forced <= 1'b0;
      end
      if (!forced && auto_enable && closed) begin
        active_memory <= telecoil_pkg::mem_d;
      end else if (forced && (deb_done || !auto_enable)) begin
        active_memory <= saved_memory;
      end else if (!forced) begin
        active_memory <= user_eff;
      end
      active_front_end <= front_end_cfg[3*active_memory +: 3];
    end
  end

  assign telecoil_forced = forced;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire logic [31:0] status_word = {26'h0, deb_running, closed,
                                   forced, 1'b0, active_memory};
  wire logic [31:0] ctrl_word = {26'h0, user_memory, 2'b00,
                                 pull_high, auto_enable};
  logic [31:0] rd_mux;

  always_comb begin
    unique case (word_addr)
      telecoil_pkg::ctrl_addr: rd_mux = ctrl_word;
      telecoil_pkg::debounce_addr: rd_mux = 32'(debounce_period);
      telecoil_pkg::valid_addr: rd_mux = {28'h0, valid_mask};
      telecoil_pkg::front_end_addr: rd_mux = {20'h0, front_end_cfg};
      telecoil_pkg::status_addr: rd_mux = status_word;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (access && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

endmodule // telecoil_memory_switch

// ==== test/magnetic_pickup_input_props.sv ====
// assertion checker for the telecoil memory switch
`timescale 1ns/1ns
module telecoil_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic memory_select_input_two,
  input wire logic [1:0] active_memory,
  input wire logic telecoil_forced
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire sw = memory_select_input_two;
  logic [1:0] last_mem;
  // memory chosen before the forced jump
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) last_mem <= 2'b00;
    else if (!telecoil_forced) last_mem <= active_memory;
  property p_in_d; telecoil_forced |-> active_memory == 2'b11; endproperty
  a_in_d: assert property (p_in_d) else $error("forced not d");
  property p_edge; $rose(telecoil_forced) |-> $past(sw) != $past(sw, 2);
  endproperty
  a_edge: assert property (p_edge) else $error("late force");
  property p_rst; $rose(hresetn) |-> active_memory == 2'b00; endproperty
  a_rst: assert property (p_rst) else $error("not a");
  property p_back; $fell(telecoil_forced) |-> active_memory == last_mem;
  endproperty
  a_back: assert property (p_back) else $error("bad restore");
  property p_quiet;
    $fell(telecoil_forced) |-> $past(sw) == $past(sw, 2)
      && $past(sw, 2) == $past(sw, 3);
  endproperty
  a_quiet: assert property (p_quiet) else $error("left early");
  property p_hold; telecoil_forced && $changed(sw) |=> telecoil_forced [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_stay; $rose(telecoil_forced) |=> telecoil_forced; endproperty
  a_stay: assert property (p_stay) else $error("no debounce");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus response");
endmodule // telecoil_props

bind telecoil_memory_switch telecoil_props u_props (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .memory_select_input_two(memory_select_input_two),
  .active_memory(active_memory), .telecoil_forced(telecoil_forced));

// ==== test/reed_switch_model.sv ====
// reed switch and its pull resistor on the memory-select line
`timescale 1ns/1ns
module reed_switch_model (
  input wire logic closed,
  input wire logic pull_high,
  output logic level
);
  // open contact leaves the line at the pull level
  assign level = pull_high ? ~closed : closed;
endmodule // reed_switch_model

// ==== test/testbench.sv ====
// self-checking bench for the telecoil memory switch
`timescale 1ns/1ns
module testbench;
  localparam int period = 4;
  logic hclk = 0, hresetn = 0, hwrite = 0, closed = 0, pull_high = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0, active_memory;
  logic [2:0] active_front_end;
  logic hreadyout, hresp, telecoil_forced, msi;
  int n_fail = 0, check_count = 0, cyc = 0, n;
  initial forever #4 hclk = ~hclk;
  telecoil_memory_switch dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .memory_select_input_two(msi),
    .active_memory(active_memory), .active_front_end(active_front_end),
    .telecoil_forced(telecoil_forced));
  reed_switch_model sw (.closed(closed), .pull_high(pull_high), .level(msi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    bus(0, telecoil_pkg::debounce_addr, 0);
    chk(rd, {16'h0, telecoil_pkg::debounce_reset});
    bus(0, telecoil_pkg::valid_addr, 0);
    chk(rd, 32'h1);
    bus(0, 8'h14, 0);
    chk(rd, 32'h0);
    chk(active_memory, 2'b00);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      bus(1, telecoil_pkg::front_end_addr, m);
      repeat (2) @(negedge hclk);
      chk(active_front_end, m);
    end
  endtask
  task automatic t_auto(input logic pu, input logic [1:0] user);
    // auto off while the pull level flips, or the swap reads as a close
    bus(1, telecoil_pkg::ctrl_addr, {26'h0, user, 2'b00, pu, 1'b0});
    pull_high <= pu;
    bus(1, telecoil_pkg::ctrl_addr, {26'h0, user, 2'b00, pu, 1'b1});
    repeat (3) @(negedge hclk);
    chk(active_memory, user);
    @(posedge hclk) closed <= 1;
    repeat (2) @(negedge hclk);
    chk(active_memory, 2'b11);
    chk(telecoil_forced, 1'b1);
    @(negedge hclk) chk(active_front_end, 3'd5);
    @(posedge hclk) closed <= 0;
    repeat (3) @(posedge hclk);
    closed <= 1;
    @(posedge hclk) closed <= 0;
    n = 0;
    while (telecoil_forced === 1'b1 && n < 40) begin
      @(negedge hclk);
      n++;
    end
    // release sample plus period more open samples, seen one negedge later
    chk(n, period + 2);
    chk(active_memory, user);
  endtask
  task automatic t_disable;
    // dropping auto while forced hands back the saved memory at once
    bus(1, telecoil_pkg::ctrl_addr, {26'h0, 2'b10, 2'b00, pull_high, 1'b1});
    @(posedge hclk) closed <= 1;
    repeat (2) @(negedge hclk);
    chk(telecoil_forced, 1'b1);
    bus(1, telecoil_pkg::ctrl_addr, {26'h0, 2'b10, 2'b00, pull_high, 1'b0});
    repeat (2) @(negedge hclk);
    chk(telecoil_forced, 1'b0);
    chk(active_memory, 2'b10);
    @(posedge hclk) closed <= 0;
  endtask
  task automatic t_fallback;
    bus(1, telecoil_pkg::valid_addr, 32'h4);
    bus(0, telecoil_pkg::valid_addr, 0);
    chk(rd, 32'h5);
    bus(1, telecoil_pkg::ctrl_addr, {26'h0, 2'b11, 2'b00, pull_high, 1'b0});
    repeat (2) @(negedge hclk);
    chk(active_memory, 2'b00);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    t_reset();
    t_modes();
    bus(1, telecoil_pkg::valid_addr, 32'hf);
    bus(1, telecoil_pkg::front_end_addr, 32'ha88);
    bus(1, telecoil_pkg::debounce_addr, period);
    t_auto(1'b1, 2'b01);
    t_auto(1'b0, 2'b10);
    t_disable();
    t_fallback();
    end_of_test();
  end
endmodule // testbench
